/* src/omsa_pkg.sv */
package omsa_pkg;

   // ----------------------------------------------------------------
   // address map
   // ----------------------------------------------------------------
   localparam logic [31:0] SRAM_FIRST = 32'h0008_0000;
   localparam logic [31:0] SRAM_LAST = 32'h000F_FFFF;
   localparam logic [31:0] BSWAP_OFS = 32'h2080_0000;
   localparam logic [31:0] HSWAP_OFS = 32'h2040_0000;
   localparam logic [31:0] RET_BASE = 32'h0018_0000;
   localparam logic [31:0] OTP_WIN_BASE = 32'h0020_0000;
   localparam logic [31:0] OTP_WIN_LAST = 32'h0020_07FF;
   localparam int SRAM_WORDS_DEF = 131072;
   localparam int RET_WORDS_DEF = 1024;

   // ----------------------------------------------------------------
   // otp word map
   // ----------------------------------------------------------------
   localparam int OTP_AW = 9;
   localparam int OTP_WORDS = 512;
   localparam logic [8:0] OTP_RSV_LAST = 9'h0FF;
   localparam logic [8:0] OTP_MAC_FIRST = 9'h100;
   localparam logic [8:0] OTP_MAC_LAST = 9'h107;
   localparam logic [8:0] OTP_XTAL0 = 9'h10A;
   localparam logic [8:0] OTP_XTAL1 = 9'h10B;
   localparam logic [8:0] OTP_USER_FIRST = 9'h10C;
   localparam logic [8:0] OTP_USER_LAST = 9'h1FE;
   localparam logic [8:0] OTP_LOCK_WORD = 9'h0FF;
   localparam logic [4:0] OTP_LOCK_BIT = 5'h1F;

   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int CLK_MHZ = 50;
   localparam int OTP_PROG_NS = 10000;
   localparam int OTP_READ_NS = 100;
   localparam int OTP_PROG_CYC = (OTP_PROG_NS * CLK_MHZ + 999) / 1000;
   localparam int OTP_READ_CYC = (OTP_READ_NS * CLK_MHZ + 999) / 1000;
   localparam int CNT_W = 16;
   localparam logic [1:0] SLEEP_MODE2 = 2'h2;
   localparam logic [1:0] SLEEP_MODE3 = 2'h3;

   // ----------------------------------------------------------------
   // types
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      PWR_ACTIVE = 2'b00, PWR_ENTER = 2'b01, PWR_ASLEEP = 2'b11, PWR_WAKE = 2'b10
   } omsa_pwr_t;
   typedef enum logic [1:0] {BUS_IDLE = 2'b00, BUS_OTP = 2'b01, BUS_DONE = 2'b11} omsa_bus_st_t;
   typedef enum logic [1:0] {OTP_IDLE = 2'b00, OTP_READ = 2'b01, OTP_PROG = 2'b11} omsa_otp_st_t;
   typedef enum logic [1:0] {SWAP_NONE = 2'b00, SWAP_BYTE = 2'b01, SWAP_HALF = 2'b10} omsa_swap_t;
   typedef enum logic [2:0] {
      FLD_RSV = 3'h0, FLD_MAC = 3'h1, FLD_XTAL = 3'h2, FLD_USER = 3'h3, FLD_NONE = 3'h4
   } omsa_field_t;

   typedef struct packed {
      logic valid;
      logic write;
      logic [31:0] addr;
      logic [31:0] wdata;
      logic [3:0] be;
   } omsa_bus_req_t;
   typedef struct packed {
      logic ready;
      logic err;
      logic [31:0] rdata;
   } omsa_bus_rsp_t;
   typedef struct packed {
      logic valid;
      logic prog;
      logic [8:0] word;
      logic [4:0] bit_idx;
   } omsa_otp_cmd_t;
   typedef struct packed {
      logic done;
      logic err;
      logic [31:0] rdata;
   } omsa_otp_rsp_t;

   function automatic omsa_field_t otp_field(input logic [8:0] w);
      if (w <= OTP_RSV_LAST) begin
         otp_field = FLD_RSV;
      end else if (w >= OTP_MAC_FIRST && w <= OTP_MAC_LAST) begin
         otp_field = FLD_MAC;
      end else if (w == OTP_XTAL0 || w == OTP_XTAL1) begin
         otp_field = FLD_XTAL;
      end else if (w >= OTP_USER_FIRST && w <= OTP_USER_LAST) begin
         otp_field = FLD_USER;
      end else begin
         otp_field = FLD_NONE;
      end
   endfunction

endpackage

/* src/omsa_swap.sv */
`timescale 1ns/1ps
`default_nettype none
module omsa_swap (
   input wire logic [31:0] din,
   input wire omsa_pkg::omsa_swap_t mode,
   output logic [31:0] dout
);
   wire logic [31:0] byte_rev = {din[7:0], din[15:8], din[23:16], din[31:24]};
   wire logic [31:0] half_rev = {din[15:0], din[31:16]};
   assign dout = (mode == omsa_pkg::SWAP_BYTE) ? byte_rev :
                 (mode == omsa_pkg::SWAP_HALF) ? half_rev : din;
endmodule
`default_nettype wire

/* src/omsa_otp_ctrl.sv */
`timescale 1ns/1ps
`default_nettype none
module omsa_otp_ctrl #(
   parameter int PROG_CYCLES = omsa_pkg::OTP_PROG_CYC,
   parameter int READ_CYCLES = omsa_pkg::OTP_READ_CYC
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire omsa_pkg::omsa_otp_cmd_t cmd,
   output omsa_pkg::omsa_otp_rsp_t rsp,
   output logic busy,
   output logic locked
);
   localparam logic [omsa_pkg::CNT_W-1:0] PROG_LOAD = omsa_pkg::CNT_W'(PROG_CYCLES);
   localparam logic [omsa_pkg::CNT_W-1:0] READ_LOAD = omsa_pkg::CNT_W'(READ_CYCLES);
   localparam logic [omsa_pkg::CNT_W-1:0] CNT_ONE = omsa_pkg::CNT_W'(1);

   // blank array reads as all zero
   logic [31:0] otp_mem [omsa_pkg::OTP_WORDS] = '{default: 32'h0};
   omsa_pkg::omsa_otp_st_t st;
   logic [omsa_pkg::CNT_W-1:0] cnt;
   logic [8:0] word_q;
   logic [4:0] bit_q;

   // ----------------------------------------------------------------
   // command acceptance
   // ----------------------------------------------------------------
   wire omsa_pkg::omsa_field_t field = omsa_pkg::otp_field(cmd.word);
   wire logic accept = (st == omsa_pkg::OTP_IDLE) && cmd.valid;
   wire logic refuse = (field == omsa_pkg::FLD_NONE) ||
                       ((field == omsa_pkg::FLD_RSV) && locked);
   wire logic start = accept && !refuse;
   wire logic finish = (st != omsa_pkg::OTP_IDLE) && (cnt == CNT_ONE);
   wire logic prog_fire = finish && (st == omsa_pkg::OTP_PROG);

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st <= omsa_pkg::OTP_IDLE;
         cnt <= '0;
         word_q <= '0;
         bit_q <= '0;
         busy <= 1'b0;
         locked <= 1'b0;
         rsp <= '0;
      end else begin
         locked <= otp_mem[omsa_pkg::OTP_LOCK_WORD][omsa_pkg::OTP_LOCK_BIT];
         rsp.done <= finish || (accept && refuse);
         rsp.err <= accept && refuse;
         if (start) begin
            st <= cmd.prog ? omsa_pkg::OTP_PROG : omsa_pkg::OTP_READ;
            cnt <= cmd.prog ? PROG_LOAD : READ_LOAD;
            word_q <= cmd.word;
            bit_q <= cmd.bit_idx;
            busy <= 1'b1;
         end else if (finish) begin
            st <= omsa_pkg::OTP_IDLE;
            busy <= 1'b0;
            rsp.rdata <= otp_mem[word_q];
         end else if (st != omsa_pkg::OTP_IDLE) begin
            cnt <= cnt - CNT_ONE;
         end
      end
   end

   // one bit per program command, never cleared
   always_ff @(posedge clk) begin
      if (prog_fire) begin
         otp_mem[word_q][bit_q] <= 1'b1;
      end
   end
endmodule
`default_nettype wire

/* src/omsa_mem_top.sv */
`timescale 1ns/1ps
`default_nettype none
module omsa_mem_top #(
   parameter int SRAM_WORDS = omsa_pkg::SRAM_WORDS_DEF,
   parameter int RET_WORDS = omsa_pkg::RET_WORDS_DEF,
   parameter int OTP_PROG_CYCLES = omsa_pkg::OTP_PROG_CYC,
   parameter int OTP_READ_CYCLES = omsa_pkg::OTP_READ_CYC
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire omsa_pkg::omsa_bus_req_t cpu_req,
   output var omsa_pkg::omsa_bus_rsp_t cpu_rsp,
   input wire omsa_pkg::omsa_otp_cmd_t otp_cmd,
   output var omsa_pkg::omsa_otp_rsp_t otp_rsp,
   output var logic otp_busy,
   output var logic otp_locked,
   input wire logic sleep_req,
   input wire logic [1:0] sleep_mode,
   input wire logic wake_req,
   output var logic asleep,
   output var logic sram_stale,
   output var logic ret_lost
);
   localparam int SRAM_AW = $clog2(SRAM_WORDS);
   localparam int RET_AW = $clog2(RET_WORDS);
   localparam logic [31:0] RET_LAST = omsa_pkg::RET_BASE + 32'(RET_WORDS * 4) - 32'h0000_0001;

   // ----------------------------------------------------------------
   // reset release
   // ----------------------------------------------------------------
   logic rst_q1;
   logic rst_sync_n;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rst_q1 <= 1'b0;
         rst_sync_n <= 1'b0;
      end else begin
         rst_q1 <= 1'b1;
         rst_sync_n <= rst_q1;
      end
   end

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   function automatic logic in_sram(input logic [31:0] a);
      in_sram = (a >= omsa_pkg::SRAM_FIRST) && (a <= omsa_pkg::SRAM_LAST);
   endfunction

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                         input logic [3:0] be);
      merge = old;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            merge[8*i +: 8] = wd[8*i +: 8];
         end
      end
   endfunction

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   logic [31:0] sram_mem [SRAM_WORDS];
   logic [31:0] ret_mem [RET_WORDS];
   logic [RET_WORDS-1:0] ret_valid;
   omsa_pkg::omsa_bus_st_t bus_st;
   omsa_pkg::omsa_bus_st_t next_bus_st;
   omsa_pkg::omsa_pwr_t pwr_st;
   omsa_pkg::omsa_pwr_t next_pwr_st;
   logic deep;
   omsa_pkg::omsa_otp_rsp_t ctrl_rsp;
   omsa_pkg::omsa_otp_cmd_t ctrl_cmd;
   omsa_pkg::omsa_otp_cmd_t cpu_otp_cmd;
   omsa_pkg::omsa_bus_rsp_t next_cpu_rsp;
   omsa_pkg::omsa_otp_rsp_t next_otp_rsp;
   omsa_pkg::omsa_swap_t swap_mode;
   logic [31:0] swapped;

   // ----------------------------------------------------------------
   // address decode
   // ----------------------------------------------------------------
   wire logic [31:0] addr = cpu_req.addr;
   wire logic [31:0] bs_addr = addr - omsa_pkg::BSWAP_OFS;
   wire logic [31:0] hs_addr = addr - omsa_pkg::HSWAP_OFS;
   wire logic hit_plain = in_sram(addr);
   wire logic hit_bswap = in_sram(bs_addr);
   wire logic hit_hswap = in_sram(hs_addr);
   wire logic hit_alias = hit_bswap || hit_hswap;
   wire logic hit_ret = (addr >= omsa_pkg::RET_BASE) && (addr <= RET_LAST);
   wire logic hit_otp = (addr >= omsa_pkg::OTP_WIN_BASE) && (addr <= omsa_pkg::OTP_WIN_LAST);
   wire logic unmapped = !(hit_plain || hit_alias || hit_ret || hit_otp);
   wire logic alias_write = cpu_req.write && hit_alias;
   wire logic otp_write = cpu_req.write && hit_otp;
   wire logic req_err = unmapped || alias_write || otp_write;

   wire logic [31:0] sram_addr = hit_bswap ? bs_addr : (hit_hswap ? hs_addr : addr);
   wire logic [31:0] sram_off = sram_addr - omsa_pkg::SRAM_FIRST;
   wire logic [31:0] ret_off = addr - omsa_pkg::RET_BASE;
   wire logic [SRAM_AW-1:0] sram_idx = sram_off[SRAM_AW+1:2];
   wire logic [RET_AW-1:0] ret_idx = ret_off[RET_AW+1:2];
   wire logic [8:0] otp_word = addr[omsa_pkg::OTP_AW+1:2];

   assign swap_mode = hit_bswap ? omsa_pkg::SWAP_BYTE :
                      (hit_hswap ? omsa_pkg::SWAP_HALF : omsa_pkg::SWAP_NONE);

   // ----------------------------------------------------------------
   // request acceptance
   // ----------------------------------------------------------------
   wire logic pwr_up = (pwr_st == omsa_pkg::PWR_ACTIVE);
   wire logic can_take = rst_sync_n && pwr_up && (bus_st == omsa_pkg::BUS_IDLE) && cpu_req.valid;
   wire logic otp_read_req = hit_otp && !cpu_req.write;
   wire logic otp_free = !otp_busy && !otp_cmd.valid;
   wire logic take_otp = can_take && otp_read_req && otp_free;
   wire logic take_now = can_take && !otp_read_req;
   wire logic sram_we = take_now && hit_plain && cpu_req.write;
   wire logic ret_we = take_now && hit_ret && cpu_req.write;
   wire logic otp_back = (bus_st == omsa_pkg::BUS_OTP) && ctrl_rsp.done;

   // ----------------------------------------------------------------
   // storage
   // ----------------------------------------------------------------
   wire logic [31:0] sram_rd = sram_mem[sram_idx];
   wire logic [31:0] ret_rd = ret_valid[ret_idx] ? ret_mem[ret_idx] : '0;
   wire logic [31:0] sram_wr = merge(sram_rd, cpu_req.wdata, cpu_req.be);
   wire logic [31:0] ret_wr = merge(ret_rd, cpu_req.wdata, cpu_req.be);

   always_ff @(posedge clk) begin
      if (sram_we) begin
         sram_mem[sram_idx] <= sram_wr;
      end
      if (ret_we) begin
         ret_mem[ret_idx] <= ret_wr;
      end
   end

   // ----------------------------------------------------------------
   // retention bookkeeping
   // ----------------------------------------------------------------
   // mode 2 drops every retained word; mode 3 keeps them
   wire logic ret_drop = (pwr_st == omsa_pkg::PWR_ENTER) && !deep;

   always_ff @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         ret_valid <= '0;
      end else if (ret_drop) begin
         ret_valid <= '0;
      end else if (ret_we) begin
         ret_valid[ret_idx] <= 1'b1;
      end
   end

   wire logic [31:0] rd_word = hit_ret ? ret_rd : sram_rd;

   omsa_swap u_swap (
      .din(rd_word),
      .mode(swap_mode),
      .dout(swapped)
   );

   // ----------------------------------------------------------------
   // otp controller, shared by command port and cpu window
   // ----------------------------------------------------------------
   assign cpu_otp_cmd = '{valid: 1'b1, prog: 1'b0, word: otp_word, bit_idx: 5'h00};
   assign ctrl_cmd = take_otp ? cpu_otp_cmd : otp_cmd;

   omsa_otp_ctrl #(
      .PROG_CYCLES(OTP_PROG_CYCLES),
      .READ_CYCLES(OTP_READ_CYCLES)
   ) u_otp (
      .clk(clk),
      .rst_n(rst_sync_n),
      .cmd(ctrl_cmd),
      .rsp(ctrl_rsp),
      .busy(otp_busy),
      .locked(otp_locked)
   );

   // ----------------------------------------------------------------
   // bus sequencer
   // ----------------------------------------------------------------
   always_comb begin
      next_bus_st = bus_st;
      case (bus_st)
         omsa_pkg::BUS_IDLE: begin
            if (take_otp) begin
               next_bus_st = omsa_pkg::BUS_OTP;
            end else if (take_now) begin
               next_bus_st = omsa_pkg::BUS_DONE;
            end
         end
         omsa_pkg::BUS_OTP: begin
            if (ctrl_rsp.done) begin
               next_bus_st = omsa_pkg::BUS_DONE;
            end
         end
         omsa_pkg::BUS_DONE: begin
            next_bus_st = omsa_pkg::BUS_IDLE;
         end
         default: begin
            next_bus_st = omsa_pkg::BUS_IDLE;
         end
      endcase
   end

   // ----------------------------------------------------------------
   // response registers
   // ----------------------------------------------------------------
   wire logic rd_ok = take_now && !req_err && !cpu_req.write;
   wire logic otp_ok = otp_back && !ctrl_rsp.err;
   wire logic to_port = (bus_st != omsa_pkg::BUS_OTP);

   assign next_cpu_rsp.ready = take_now || otp_back;
   assign next_cpu_rsp.err = take_now ? req_err : (otp_back && ctrl_rsp.err);
   assign next_cpu_rsp.rdata = rd_ok ? swapped : (otp_ok ? ctrl_rsp.rdata : '0);
   assign next_otp_rsp.done = ctrl_rsp.done && to_port;
   assign next_otp_rsp.err = ctrl_rsp.err && to_port;
   assign next_otp_rsp.rdata = ctrl_rsp.rdata;

   always_ff @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         bus_st <= omsa_pkg::BUS_IDLE;
         cpu_rsp <= '0;
         otp_rsp <= '0;
      end else begin
         bus_st <= next_bus_st;
         cpu_rsp <= next_cpu_rsp;
         otp_rsp <= next_otp_rsp;
      end
   end

   // ----------------------------------------------------------------
   // sleep sequencing
   // ----------------------------------------------------------------
   wire logic mode_ok = (sleep_mode == omsa_pkg::SLEEP_MODE2) ||
                        (sleep_mode == omsa_pkg::SLEEP_MODE3);

   always_comb begin
      next_pwr_st = pwr_st;
      case (pwr_st)
         omsa_pkg::PWR_ACTIVE: begin
            if (sleep_req && mode_ok) begin
               next_pwr_st = omsa_pkg::PWR_ENTER;
            end
         end
         omsa_pkg::PWR_ENTER: begin
            next_pwr_st = omsa_pkg::PWR_ASLEEP;
         end
         omsa_pkg::PWR_ASLEEP: begin
            if (wake_req) begin
               next_pwr_st = omsa_pkg::PWR_WAKE;
            end
         end
         omsa_pkg::PWR_WAKE: begin
            next_pwr_st = omsa_pkg::PWR_ACTIVE;
         end
         default: begin
            next_pwr_st = omsa_pkg::PWR_ACTIVE;
         end
      endcase
   end

   wire logic enter_now = pwr_up && sleep_req && mode_ok;
   wire logic go_deep = (sleep_mode == omsa_pkg::SLEEP_MODE3);
   wire logic waking = (pwr_st == omsa_pkg::PWR_WAKE);
   // stale until software rewrites SRAM; the wake event wins
   wire logic next_stale = waking || (sram_stale && !sram_we);
   wire logic next_lost = ret_drop || (ret_lost && !ret_we);

   always_ff @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         pwr_st <= omsa_pkg::PWR_ACTIVE;
         deep <= 1'b0;
         asleep <= 1'b0;
         sram_stale <= 1'b0;
         ret_lost <= 1'b0;
      end else begin
         pwr_st <= next_pwr_st;
         if (enter_now) begin
            deep <= go_deep;
         end
         asleep <= (next_pwr_st != omsa_pkg::PWR_ACTIVE);
         sram_stale <= next_stale;
         ret_lost <= next_lost;
      end
   end
endmodule
`default_nettype wire

/* verification/omsa_mem_top_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
module omsa_mem_top_asserts #(
   parameter int OTP_PROG_CYCLES = 4,
   parameter int OTP_READ_CYCLES = 2
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire omsa_pkg::omsa_bus_req_t cpu_req,
   input wire omsa_pkg::omsa_bus_rsp_t cpu_rsp,
   input wire omsa_pkg::omsa_otp_cmd_t otp_cmd,
   input wire omsa_pkg::omsa_otp_rsp_t otp_rsp,
   input wire logic otp_busy,
   input wire logic otp_locked,
   input wire logic sleep_req,
   input wire logic [1:0] sleep_mode,
   input wire logic wake_req,
   input wire logic asleep,
   input wire logic sram_stale,
   input wire logic ret_lost
);
   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   logic [15:0] busy_len;
   wire logic [31:0] a_b = cpu_req.addr - omsa_pkg::BSWAP_OFS;
   wire logic [31:0] a_h = cpu_req.addr - omsa_pkg::HSWAP_OFS;
   wire logic in_sram = cpu_req.addr >= omsa_pkg::SRAM_FIRST
      && cpu_req.addr <= omsa_pkg::SRAM_LAST;
   wire logic in_swap = (a_b >= omsa_pkg::SRAM_FIRST && a_b <= omsa_pkg::SRAM_LAST)
      || (a_h >= omsa_pkg::SRAM_FIRST && a_h <= omsa_pkg::SRAM_LAST);
   wire logic in_hole = cpu_req.addr >= 32'h0010_0000 && cpu_req.addr < omsa_pkg::RET_BASE;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         busy_len <= 16'h0000;
      end else begin
         busy_len <= otp_busy ? busy_len + 16'h0001 : 16'h0000;
      end
   end
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);
   sequence s_new_req;
      $rose(cpu_req.valid) && !asleep;
   endsequence
   sequence s_sleep_go;
      sleep_req && !asleep;
   endsequence
   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   rdy_pulse_a: assert property (cpu_rsp.ready |=> !cpu_rsp.ready) else $error("ready held");
   sram_lat_a: assert property ((s_new_req ##0 in_sram) |=> cpu_rsp.ready && !cpu_rsp.err)
      else $error("sram access not answered in one cycle");
   swap_wr_err_a: assert property ((s_new_req ##0 (in_swap && cpu_req.write))
      |=> cpu_rsp.ready && cpu_rsp.err) else $error("swap window write accepted");
   hole_err_a: assert property ((s_new_req ##0 in_hole) |=> cpu_rsp.ready && cpu_rsp.err)
      else $error("unmapped access accepted");
   err_zero_a: assert property (cpu_rsp.ready && cpu_rsp.err |-> cpu_rsp.rdata == 32'h0)
      else $error("error response with data");
   busy_len_a: assert property ($fell(otp_busy)
      |-> busy_len == OTP_PROG_CYCLES || busy_len == OTP_READ_CYCLES) else $error("busy length");
   otp_done_a: assert property ($fell(otp_busy) |-> ##[0:1] (otp_rsp.done || cpu_rsp.ready))
      else $error("otp done missing");
   lock_hold_a: assert property (otp_locked |=> otp_locked) else $error("lock dropped");
   sleep_enter_a: assert property ((s_sleep_go ##0 sleep_mode[1]) |=> asleep)
      else $error("sleep not entered");
   mode2_drop_a: assert property ((s_sleep_go ##0 sleep_mode == omsa_pkg::SLEEP_MODE2)
      |-> ##[1:3] ret_lost) else $error("mode 2 kept retention");
   mode3_keep_a: assert property ((s_sleep_go ##0 sleep_mode == omsa_pkg::SLEEP_MODE3)
      ##0 !ret_lost |=> !ret_lost [*3]) else $error("mode 3 lost retention");
   wake_stale_a: assert property ($fell(asleep) |-> ##[0:1] sram_stale)
      else $error("sram not stale after wake");
endmodule
bind omsa_mem_top omsa_mem_top_asserts #(.OTP_PROG_CYCLES(OTP_PROG_CYCLES),
   .OTP_READ_CYCLES(OTP_READ_CYCLES)) i_chk (.clk(clk), .rst_n(rst_n), .cpu_req(cpu_req),
   .cpu_rsp(cpu_rsp), .otp_cmd(otp_cmd), .otp_rsp(otp_rsp), .otp_busy(otp_busy),
   .otp_locked(otp_locked), .sleep_req(sleep_req), .sleep_mode(sleep_mode), .wake_req(wake_req),
   .asleep(asleep), .sram_stale(sram_stale), .ret_lost(ret_lost));
`default_nettype wire

/* verification/omsa_cpu_model.sv */
`timescale 1ns/1ps
`default_nettype none
module omsa_cpu_model (
   input wire logic clk,
   input wire logic go,
   input wire logic wr,
   input wire logic [31:0] addr,
   input wire logic [31:0] wdata,
   output wire omsa_pkg::omsa_bus_req_t cpu_req,
   input wire omsa_pkg::omsa_bus_rsp_t cpu_rsp,
   output wire logic done,
   output wire logic [32:0] res
);
   omsa_pkg::omsa_bus_req_t q = '0;
   logic d = 1'b0;
   logic [32:0] r = 33'h0;
   assign cpu_req = q;
   assign done = d;
   assign res = r;
   // request held until ready, then address, data and byte enables inverted
   always @(posedge clk) begin
      d <= 1'b0;
      if (q.valid && cpu_rsp.ready === 1'b1) begin
         q.valid <= 1'b0;
         q.addr <= ~q.addr;
         q.wdata <= ~q.wdata;
         q.be <= ~q.be;
         d <= 1'b1;
         r <= {cpu_rsp.err, cpu_rsp.rdata};
      end else if (go && !q.valid) begin
         q <= '{1'b1, wr, addr, wdata, 4'hF};
      end
   end
endmodule
`default_nettype wire

/* verification/omsa_mem_top_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module omsa_mem_top_bench;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic go = 1'b0;
   logic wr = 1'b0;
   logic [31:0] ad = 32'h0;
   logic [31:0] wd = 32'h0;
   logic done;
   logic [32:0] res;
   omsa_pkg::omsa_bus_req_t cpu_req;
   omsa_pkg::omsa_bus_rsp_t cpu_rsp;
   omsa_pkg::omsa_otp_cmd_t otp_cmd = '0;
   omsa_pkg::omsa_otp_rsp_t otp_rsp;
   logic otp_busy, otp_locked, asleep, sram_stale, ret_lost;
   logic sleep_req = 1'b0;
   logic [1:0] sleep_mode = 2'h0;
   logic wake_req = 1'b0;
   int err_total = 0;
   int cmp_count = 0;
   int seed = 3;
   int cyc = 0;
   bit lk = 1'b0;
   logic [31:0] om [512];
   logic [8:0] wl [9] = '{9'h100, 9'h107, 9'h10A, 9'h10B, 9'h108, 9'h109, 9'h1FE, 9'h1FF, 9'h000};

   omsa_mem_top #(.SRAM_WORDS(1024), .RET_WORDS(16), .OTP_PROG_CYCLES(4), .OTP_READ_CYCLES(2))
   i_dut (.clk(clk), .rst_n(rst_n), .cpu_req(cpu_req), .cpu_rsp(cpu_rsp), .otp_cmd(otp_cmd),
      .otp_rsp(otp_rsp), .otp_busy(otp_busy), .otp_locked(otp_locked), .sleep_req(sleep_req),
      .sleep_mode(sleep_mode), .wake_req(wake_req), .asleep(asleep), .sram_stale(sram_stale),
      .ret_lost(ret_lost));
   omsa_cpu_model i_cpu (.clk(clk), .go(go), .wr(wr), .addr(ad), .wdata(wd), .cpu_req(cpu_req),
      .cpu_rsp(cpu_rsp), .done(done), .res(res));

   initial forever #10 clk = ~clk;
   always @(posedge clk) begin
      cyc++;
      if (cyc > 5000) begin
         err_total++;
         give_verdict();
      end
   end

   // ----------------------------------------------------------------
   // tasks
   // ----------------------------------------------------------------
   task automatic give_verdict();
      if (err_total == 0 && cmp_count > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [32:0] e, input logic [32:0] g);
      cmp_count++;
      if (g !== e) begin
         err_total++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic cpu(input logic w, input logic [31:0] a, input logic [31:0] d);
      int n;
      n = 0;
      go = 1'b1;
      wr = w;
      ad = a;
      wd = d;
      @(posedge clk);
      #1 go = 1'b0;
      while (done !== 1'b1 && n < 40) begin
         @(posedge clk);
         #1 n++;
      end
      chk("cpu_ready", 33'h1, {32'h0, done});
   endtask
   task automatic rd(input string nm, input logic [31:0] a, input logic [32:0] e);
      cpu(1'b0, a, 32'h0);
      chk(nm, e, res);
   endtask
   task automatic otp(input logic p, input logic [8:0] w, input logic [4:0] b, input bit extra);
      logic e;
      int n;
      e = (w == 9'h108 || w == 9'h109 || w == 9'h1FF) || (lk && w <= omsa_pkg::OTP_RSV_LAST);
      n = 0;
      otp_cmd = '{1'b1, p, w, b};
      @(posedge clk);
      #1 otp_cmd.valid = 1'b0;
      if (extra) begin
         @(posedge clk);
         #1 otp_cmd = '{1'b1, 1'b1, w, 5'h00};
         @(posedge clk);
         #1 otp_cmd.valid = 1'b0;
      end
      while (otp_rsp.done !== 1'b1 && n < 600) begin
         @(posedge clk);
         #1 n++;
      end
      if (!e && p) om[w] = om[w] | (32'h1 << b);
      chk("otp_err", {32'h0, e}, {32'h0, otp_rsp.err});
      if (!p && !e) chk("otp_rdata", {1'b0, om[w]}, {1'b0, otp_rsp.rdata});
      @(posedge clk);
      #1;
   endtask
   task automatic slp(input logic [1:0] m);
      sleep_req = 1'b1;
      sleep_mode = m;
      @(posedge clk);
      #1 sleep_req = 1'b0;
      repeat (3) @(posedge clk);
      #1 wake_req = 1'b1;
      @(posedge clk);
      #1 wake_req = 1'b0;
      repeat (4) @(posedge clk);
      #1 chk("sram_stale", 33'h1, {32'h0, sram_stale});
      chk("ret_lost", {32'h0, m == omsa_pkg::SLEEP_MODE2}, {32'h0, ret_lost});
   endtask

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      logic [31:0] d, a, r;
      int i;
      om = '{default: 32'h0};
      repeat (8) @(posedge clk);
      #1 rst_n = 1'b1;
      repeat (3) @(posedge clk);
      #1;
      for (i = 0; i < 3; i++) begin
         d = $random(seed);
         a = (i == 0) ? omsa_pkg::SRAM_FIRST : (i == 1) ? omsa_pkg::SRAM_LAST - 32'h3 :
            omsa_pkg::SRAM_FIRST + {22'h0, d[7:0], 2'b00};
         cpu(1'b1, a, d);
         rd("sram", a, {1'b0, d});
         rd("bswap", a + omsa_pkg::BSWAP_OFS, {1'b0, d[7:0], d[15:8], d[23:16], d[31:24]});
         rd("hswap", a + omsa_pkg::HSWAP_OFS, {1'b0, d[15:0], d[31:16]});
         cpu(1'b1, a + (i[0] ? omsa_pkg::HSWAP_OFS : omsa_pkg::BSWAP_OFS), ~d);
         chk("swap_wr", {1'b1, 32'h0}, res);
         rd("no_reorder", a, {1'b0, d});
      end
      rd("below_sram", omsa_pkg::SRAM_FIRST - 32'h4, {1'b1, 32'h0});
      rd("above_sram", omsa_pkg::SRAM_LAST + 32'h1, {1'b1, 32'h0});
      r = $random(seed);
      cpu(1'b1, omsa_pkg::RET_BASE + 32'h4, r);
      slp(omsa_pkg::SLEEP_MODE3);
      rd("ret_m3", omsa_pkg::RET_BASE + 32'h4, {1'b0, r});
      cpu(1'b1, omsa_pkg::SRAM_FIRST, r);
      chk("stale_clr", 33'h0, {32'h0, sram_stale});
      slp(omsa_pkg::SLEEP_MODE2);
      rd("ret_m2", omsa_pkg::RET_BASE + 32'h4, 33'h0);
      cpu(1'b1, omsa_pkg::RET_BASE + 32'h4, r);
      chk("lost_clr", 33'h0, {32'h0, ret_lost});
      otp(1'b1, omsa_pkg::OTP_USER_FIRST, 5'h05, 1'b1);
      otp(1'b0, omsa_pkg::OTP_USER_FIRST, 5'h00, 1'b0);
      rd("otp_win", omsa_pkg::OTP_WIN_BASE + {21'h0, omsa_pkg::OTP_USER_FIRST, 2'b00},
         {1'b0, om[omsa_pkg::OTP_USER_FIRST]});
      for (i = 0; i < 9; i++) begin
         r = $random(seed);
         otp(1'b1, wl[i], r[4:0], 1'b0);
         otp(1'b0, wl[i], 5'h00, 1'b0);
      end
      otp(1'b1, omsa_pkg::OTP_LOCK_WORD, omsa_pkg::OTP_LOCK_BIT, 1'b0);
      lk = 1'b1;
      repeat (2) @(posedge clk);
      #1 chk("locked", 33'h1, {32'h0, otp_locked});
      otp(1'b0, 9'h000, 5'h00, 1'b0);
      otp(1'b1, 9'h010, 5'h02, 1'b0);
      rd("otp_lock_rd", omsa_pkg::OTP_WIN_BASE, {1'b1, 32'h0});
      cpu(1'b1, omsa_pkg::OTP_WIN_BASE + 32'h430, r);
      chk("otp_win_wr", {1'b1, 32'h0}, res);
      give_verdict();
   end
endmodule
`default_nettype wire
